// >>> rtl/imf_filter.sv
// IPv6 listener discovery and solicitation receive filter with output FIFO
`timescale 1ns/1ps

// ==========================================
// Output FIFO
module imf_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wp_q;
    logic [AW-1:0] rp_q;
    logic [AW:0] cnt_q;
    wire push = i_valid && o_ready;
    wire pop = o_valid && i_ready;
    assign o_ready = (cnt_q != DEPTH[AW:0]);
    assign o_valid = (cnt_q != '0);
    assign o_data = mem_q[rp_q];
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                mem_q[wp_q] <= i_data;
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// ==========================================
// Filter top
module imf_filter
    import imf_pkg::*;
#(
    parameter bit HAS_MLD = 1'b1,
    parameter bit HAS_NS = 1'b1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [IMF_FILT_W-1:0] i_filter,
    input wire logic i_other_match,
    input wire logic i_valid,
    input wire logic [IMF_DW-1:0] i_data,
    input wire logic i_last,
    output logic o_ready,
    output logic o_valid,
    output logic [IMF_DW-1:0] o_data,
    output logic o_last,
    input wire logic i_ready
);
    localparam int FW = IMF_DW + 1;
    localparam int OCC_W = $clog2(IMF_FIFO_DEPTH) + 1;
    localparam logic [OCC_W-1:0] OCC_FULL = OCC_W'(IMF_FIFO_DEPTH);
    imf_state_e st_q;
    imf_state_e st_d;
    logic [IMF_CNT_W-1:0] cnt_q;
    logic [IMF_CNT_W-1:0] cnt_d;
    logic [IMF_DW*IMF_HDR_BYTES-1:0] hdr_q;
    logic [IMF_DW*IMF_HDR_BYTES-1:0] hdr_d;
    logic [IMF_CNT_W-1:0] rp_q;
    logic [IMF_CNT_W-1:0] rp_d;
    logic rp_act_q;
    logic rp_act_d;
    logic [OCC_W-1:0] occ_q;
    logic [OCC_W-1:0] occ_d;
    logic ready_q;
    logic ready_d;
    logic [FW-1:0] fo_data;
    logic fo_valid;
    logic fo_ready;
    logic f_ready;
    logic out_valid_q;
    logic [FW-1:0] out_data_q;
    wire take = i_valid && ready_q;

    // ==========================================
    // Classification
    // Header bytes in arrival order; byte 0 is the first MAC byte
    wire [IMF_DW*IMF_HDR_BYTES-1:0] hdr_n = {hdr_q[IMF_DW*(IMF_HDR_BYTES-1)-1:0], i_data};
    function automatic logic [7:0] hb(input int k);
        hb = hdr_n[IMF_DW*(IMF_HDR_BYTES-1-k) +: IMF_DW];
    endfunction
    wire [47:0] dmac = {hb(0), hb(1), hb(2), hb(3), hb(4), hb(5)};
    wire [15:0] etype = {hb(int'(IMF_OFS_ET_HI)), hb(int'(IMF_OFS_ET_LO))};
    wire [7:0] nh = hb(int'(IMF_OFS_NH));
    wire [7:0] icmp = hb(int'(IMF_OFS_ICMP));
    wire v6_icmp = (etype == IMF_ETYPE_IPV6) && (nh == IMF_NH_ICMPV6);
    wire mac_mld = (dmac == IMF_MAC_ALLNODES);
    wire typ_mld = (icmp == IMF_ICMP_MLQ)
        || (icmp == IMF_ICMP_MLR)
        || (icmp == IMF_ICMP_MLD);
    wire mac_ns = (dmac[47:24] == IMF_MAC_SOLNODE);
    wire typ_ns = v6_icmp && (icmp == IMF_ICMP_NS);
    wire is_mld = mac_mld && v6_icmp && typ_mld;
    wire is_ns = mac_ns && typ_ns;

    // ==========================================
    // Forward decision
    // Bit 4 gates listener packets; optional
    wire fwd_mld = HAS_MLD && i_filter[IMF_BIT_MLD] && is_mld;
    wire fwd_ns = HAS_NS && i_filter[IMF_BIT_NS] && is_ns;
    wire fwd = fwd_mld || fwd_ns || i_other_match;

    // ==========================================
    // Frame decode
    wire in_hdr = (st_q == IMF_ST_HDR);
    wire in_pass = (st_q == IMF_ST_PASS);
    wire in_drop = (st_q == IMF_ST_DROP);
    wire hdr_take = take && in_hdr;
    wire at_dec = in_hdr && (cnt_q == IMF_OFS_ICMP);
    // Frames that end at or before the decision byte are dropped
    wire hdr_end = hdr_take && i_last;
    wire dec_now = hdr_take && at_dec && !i_last;
    wire pass_byte = in_pass && take && !rp_act_q;
    wire pass_end = pass_byte && i_last;
    wire drop_end = in_drop && take && i_last;
    wire cnt_sat = (cnt_q == IMF_CNT_MAX);
    // Header bytes are held until decided, then replayed if forwarded
    wire hdr_out = rp_act_q;
    wire rp_step = hdr_out && f_ready;
    wire rp_done = rp_step && (rp_q == IMF_OFS_ICMP);
    wire fi_valid = hdr_out || pass_byte;
    wire [FW-1:0] fi_data = hdr_out ?
        {1'b0, hdr_q[IMF_DW*(IMF_HDR_BYTES-1-int'(rp_q)) +: IMF_DW]} : {i_last, i_data};
    wire f_push = fi_valid && f_ready;
    wire f_pop = fo_valid && fo_ready;
    assign fo_ready = !out_valid_q || i_ready;

    // ==========================================
    // Next state
    always_comb begin
        st_d = st_q;
        case (st_q)
            IMF_ST_HDR: begin
                if (dec_now) begin
                    st_d = fwd ? IMF_ST_PASS : IMF_ST_DROP;
                end
            end
            IMF_ST_PASS: begin
                if (pass_end) begin
                    st_d = IMF_ST_HDR;
                end
            end
            IMF_ST_DROP: begin
                if (drop_end) begin
                    st_d = IMF_ST_HDR;
                end
            end
            default: begin
                st_d = IMF_ST_HDR;
            end
        endcase
    end
    assign cnt_d = (hdr_end || pass_end || drop_end) ? '0
        : ((hdr_take && !cnt_sat) ? cnt_q + 1'b1 : cnt_q);
    assign hdr_d = hdr_take ? hdr_n : hdr_q;
    assign rp_d = dec_now ? '0 : (rp_step ? rp_q + 1'b1 : rp_q);
    assign rp_act_d = dec_now ? fwd : (rp_done ? 1'b0 : rp_act_q);
    // FIFO occupancy mirror, so that ready can come from a flip-flop
    assign occ_d = occ_q + {{(OCC_W-1){1'b0}}, f_push} - {{(OCC_W-1){1'b0}}, f_pop};
    assign ready_d = (st_d == IMF_ST_HDR) || (st_d == IMF_ST_DROP)
        || ((st_d == IMF_ST_PASS) && !rp_act_d && (occ_d != OCC_FULL));

    // ==========================================
    // Frame state
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q <= IMF_ST_HDR;
            cnt_q <= '0;
            hdr_q <= '0;
            rp_q <= '0;
            rp_act_q <= 1'b0;
            occ_q <= '0;
            ready_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            hdr_q <= hdr_d;
            rp_q <= rp_d;
            rp_act_q <= rp_act_d;
            occ_q <= occ_d;
            ready_q <= ready_d;
        end
    end

    // ==========================================
    // Output FIFO instance
    imf_fifo #(.WIDTH(FW), .DEPTH(IMF_FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_valid(fi_valid),
        .o_ready(f_ready),
        .i_data(fi_data),
        .o_valid(fo_valid),
        .i_ready(fo_ready),
        .o_data(fo_data)
    );

    // ==========================================
    // Registered output stage
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            out_valid_q <= 1'b0;
            out_data_q <= '0;
        end else if (!out_valid_q || i_ready) begin
            out_valid_q <= fo_valid;
            out_data_q <= fo_data;
        end
    end
    assign o_valid = out_valid_q;
    assign o_data = out_data_q[IMF_DW-1:0];
    assign o_last = out_data_q[IMF_DW];
    assign o_ready = ready_q;

    // ==========================================
    // Checks
    // Bit four clear
    mld_blocked_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && is_mld && !i_filter[IMF_BIT_MLD] && !i_other_match)
        |=> (st_q == IMF_ST_DROP)) else $error("listener packet passed while bit clear");
    mld_forward_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && is_mld && HAS_MLD && i_filter[IMF_BIT_MLD])
        |=> (st_q == IMF_ST_PASS) && rp_act_q) else $error("listener packet dropped");
    ns_forward_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && is_ns && HAS_NS && i_filter[IMF_BIT_NS])
        |=> (st_q == IMF_ST_PASS) && rp_act_q) else $error("solicitation dropped");
    ns_blocked_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && is_ns && !i_filter[IMF_BIT_NS] && !i_other_match)
        |=> (st_q == IMF_ST_DROP)) else $error("solicitation passed while bit clear");
    no_match_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && !v6_icmp && !i_other_match)
        |=> (st_q == IMF_ST_DROP)) else $error("non-ICMPv6 packet forwarded");
    mld_mac_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && !mac_mld && !mac_ns && !i_other_match)
        |=> (st_q == IMF_ST_DROP)) else $error("foreign address forwarded");
    type_reject_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && mac_mld && v6_icmp && !typ_mld && !i_other_match)
        |=> (st_q == IMF_ST_DROP)) else $error("wrong listener type forwarded");
    ns_type_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && mac_ns && !typ_ns && !i_other_match)
        |=> (st_q == IMF_ST_DROP)) else $error("wrong solicitation type forwarded");
    omit_mld_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && !HAS_MLD && is_mld && !i_other_match)
        |=> (st_q == IMF_ST_DROP)) else $error("omitted listener filter forwarded");
    omit_ns_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && !HAS_NS && is_ns && !i_other_match)
        |=> (st_q == IMF_ST_DROP)) else $error("omitted solicitation filter forwarded");
    other_pass_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (dec_now && i_other_match)
        |=> (st_q == IMF_ST_PASS)) else $error("other match ignored");
    // Ready low during replay
    replay_stall_a: assert property (@(posedge i_clk) disable iff (i_rst)
        rp_act_q |-> !o_ready) else $error("input accepted during replay");
    // Ready high between frames
    ready_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
        in_hdr |-> o_ready) else $error("header byte refused");
    // No byte lost at the FIFO
    fifo_safe_a: assert property (@(posedge i_clk) disable iff (i_rst)
        pass_byte |-> f_ready) else $error("body byte pushed into full FIFO");
    // Forwarded frame closes
    frame_close_a: assert property (@(posedge i_clk) disable iff (i_rst)
        pass_end |=> in_hdr) else $error("frame end not seen");
    // Output holds while stalled
    stable_out_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_valid && !i_ready) |=> o_valid && $stable(o_data) && $stable(o_last))
        else $error("output changed while stalled");
endmodule

// >>> rtl/imf_pkg.sv
// Constants for the IPv6 multicast listener and solicitation filter
package imf_pkg;
    localparam int IMF_DW = 8;
    localparam int IMF_FIFO_DEPTH = 16;
    localparam int IMF_HDR_BYTES = 55;
    localparam int IMF_CNT_W = 6;
    localparam int IMF_BIT_MLD = 4;
    localparam int IMF_BIT_NS = 5;
    localparam int IMF_FILT_W = 9;
    localparam logic [47:0] IMF_MAC_ALLNODES = 48'h3333_0000_0001;
    localparam logic [23:0] IMF_MAC_SOLNODE = 24'h3333ff;
    localparam logic [15:0] IMF_ETYPE_IPV6 = 16'h86dd;
    localparam logic [7:0] IMF_NH_ICMPV6 = 8'h3a;
    localparam logic [7:0] IMF_ICMP_MLQ = 8'h82;
    localparam logic [7:0] IMF_ICMP_MLR = 8'h83;
    localparam logic [7:0] IMF_ICMP_MLD = 8'h84;
    localparam logic [7:0] IMF_ICMP_NS = 8'h87;
    // Byte offsets in the frame
    localparam logic [5:0] IMF_OFS_ET_HI = 6'h0c;
    localparam logic [5:0] IMF_OFS_ET_LO = 6'h0d;
    localparam logic [5:0] IMF_OFS_NH = 6'h14;
    localparam logic [5:0] IMF_OFS_ICMP = 6'h36;
    localparam logic [5:0] IMF_CNT_MAX = 6'h3f;
    typedef enum logic [2:0] {
        IMF_ST_HDR = 3'b001,
        IMF_ST_PASS = 3'b010,
        IMF_ST_DROP = 3'b100
    } imf_state_e;
endpackage

// >>> verif/imf_filter_tb.sv
// Self-checking bench for the listener and solicitation filter
`timescale 1ns/1ps
`define CHK(nm, e, a) begin tests_run++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected %s exp %0h got %0h", nm, e, a); end end
module imf_filter_tb
    import imf_pkg::*;
;
    logic i_clk = 0, i_rst = 1, i_other_match = 0, i_valid = 0, i_last = 0, stall = 0;
    logic [IMF_FILT_W-1:0] i_filter = '0;
    logic [IMF_DW-1:0] i_data = '0, o_data;
    logic o_ready, o_valid, o_last, i_ready;
    int frames, flen, fsum, error_cnt = 0, tests_run = 0;
    logic off_ready, off_valid, off_last;
    logic [IMF_DW-1:0] off_data;
    int off_frames = 0;
    localparam logic [47:0] NSM = 48'h3333_ffa5_5a01;
    imf_filter imf_filter_inst (.i_clk(i_clk), .i_rst(i_rst), .i_filter(i_filter),
        .i_other_match(i_other_match), .i_valid(i_valid), .i_data(i_data), .i_last(i_last),
        .o_ready(o_ready), .o_valid(o_valid), .o_data(o_data), .o_last(o_last),
        .i_ready(i_ready));
    imf_mc_model imf_mc_model_inst (.i_clk(i_clk), .i_stall(stall), .i_valid(o_valid),
        .i_data(o_data), .i_last(o_last), .o_ready(i_ready), .o_frames(frames), .o_len(flen),
        .o_sum(fsum));
    imf_filter #(.HAS_MLD(1'b0), .HAS_NS(1'b0)) imf_filter_off_inst (.i_clk(i_clk),
        .i_rst(i_rst), .i_filter(i_filter), .i_other_match(i_other_match), .i_valid(i_valid),
        .i_data(i_data), .i_last(i_last), .o_ready(off_ready), .o_valid(off_valid),
        .o_data(off_data), .o_last(off_last), .i_ready(1'b1));
    always @(posedge i_clk) begin
        if (off_valid === 1'b1 && off_last === 1'b1) off_frames++;
    end
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic frame(logic [47:0] mac, logic [15:0] et, logic [7:0] nh, logic [7:0] ty,
            logic [8:0] filt, logic oth, int exp, int len = 56);
        int f0;
        int sum;
        f0 = frames;
        sum = 0;
        i_filter = filt;
        i_other_match = oth;
        for (int i = 0; i < len; i++) begin
            i_valid = 1'b1;
            i_last = (i == len - 1);
            i_data = (i < 6) ? mac[47-8*i -: 8] : (i == 12) ? et[15:8] : (i == 13) ? et[7:0]
                : (i == 20) ? nh : (i == 54) ? ty : 8'(i);
            sum += int'(i_data);
            forever begin
                @(negedge i_clk);
                if (o_ready === 1'b1) break;
            end
            @(posedge i_clk);
            #2;
        end
        i_valid = 1'b0;
        i_last = 1'b0;
        repeat (120) @(posedge i_clk);
        #2;
        `CHK("frames", f0 + exp, frames)
        if (exp == 1) `CHK("length", len, flen)
        if (exp == 1) `CHK("sum", sum, fsum)
    endtask
    task automatic t_mld();
        logic [7:0] ty[3] = '{8'h82, 8'h83, 8'h84};
        foreach (ty[k]) frame(IMF_MAC_ALLNODES, 16'h86dd, 8'h3a, ty[k], 9'h010, 0, 1);
        frame(IMF_MAC_ALLNODES, 16'h86dd, 8'h3a, 8'h85, 9'h010, 0, 0);
        frame(IMF_MAC_ALLNODES, 16'h86dd, 8'h3a, 8'h83, 9'h1ef, 0, 0);
    endtask
    task automatic t_crit();
        frame(48'h3333_0000_0002, 16'h86dd, 8'h3a, 8'h82, 9'h010, 0, 0);
        frame(IMF_MAC_ALLNODES, 16'h86de, 8'h3a, 8'h82, 9'h010, 0, 0);
        frame(IMF_MAC_ALLNODES, 16'h86dd, 8'h3b, 8'h82, 9'h010, 0, 0);
    endtask
    task automatic t_ns();
        frame(NSM, 16'h86dd, 8'h3a, 8'h87, 9'h020, 0, 1);
        frame(48'h3333_ff00_0000, 16'h86dd, 8'h3a, 8'h87, 9'h020, 0, 1);
        frame(48'h3333_fe00_0001, 16'h86dd, 8'h3a, 8'h87, 9'h020, 0, 0);
        frame(NSM, 16'h86dd, 8'h3a, 8'h88, 9'h020, 0, 0);
        frame(NSM, 16'h0800, 8'h3a, 8'h87, 9'h020, 0, 0);
        frame(NSM, 16'h86dd, 8'h3a, 8'h87, 9'h1df, 0, 0);
        frame(NSM, 16'h86dd, 8'h3a, 8'h82, 9'h030, 0, 0);
        `CHK("omitted", 0, off_frames)
    endtask
    task automatic t_other();
        // Single address through the address filter
        frame(NSM, 16'h86dd, 8'h3a, 8'h87, 9'h000, 1, 1);
    endtask
    task automatic t_full();
        stall = 1'b1;
        fork
            begin
                repeat (150) @(negedge i_clk);
                `CHK("ready", 1'b0, o_ready)
                stall = 1'b0;
            end
        join_none
        frame(IMF_MAC_ALLNODES, 16'h86dd, 8'h3a, 8'h84, 9'h010, 0, 1, 80);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge i_clk);
        #2;
        i_rst = 1'b0;
        t_mld();
        t_crit();
        t_ns();
        t_other();
        t_full();
        end_sim();
    end
endmodule

// >>> verif/imf_mc_model.sv
// Management controller side model: byte sink with stalls
`timescale 1ns/1ps
module imf_mc_model
    import imf_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_stall,
    input wire logic i_valid,
    input wire logic [IMF_DW-1:0] i_data,
    input wire logic i_last,
    output logic o_ready,
    output int o_frames,
    output int o_len,
    output int o_sum
);
    int cnt = 0;
    int cyc = 0;
    int sum = 0;
    initial begin
        o_ready = 1'b0;
        o_frames = 0;
        o_len = 0;
        o_sum = 0;
    end
    // Counts whole frames, stalls every third cycle
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            cnt = cnt + 1;
            sum = sum + int'(i_data);
            if (i_last) begin
                o_len <= cnt;
                o_sum <= sum;
                o_frames <= o_frames + 1;
                cnt = 0;
                sum = 0;
            end
        end
        cyc = cyc + 1;
        o_ready <= #2 !i_stall && (cyc % 3 != 0);
    end
endmodule
